// File: design/lrs_regs.svh
// Purpose: Constants for the LUT storage element
// Assumes: Included by the package and the lrs_lut_store module
// Notes:   Timing counts are in sys_clk cycles
`ifndef LRS_REGS_SVH
`define LRS_REGS_SVH
`define LRS_ADDR_W      5
`define LRS_DEPTH       32
`define LRS_HALF_DEPTH  16
`define LRS_HALF_ADDR_W 4
`define LRS_FIFO_W      2
`define LRS_FIFO_DEPTH  16
`define LRS_FIFO_PTR_W  4
`define LRS_MODE_RAM    2'h0
`define LRS_MODE_RAM2   2'h1
`define LRS_MODE_SHIFT  2'h2
`define LRS_MODE_SHIFT2 2'h3
`endif

// File: design/lrs_pkg.sv
// Purpose: Types for the LUT storage element
// Assumes: lrs_regs.svh holds the numbers
// Notes:   Mode selects one of four storage behaviours
`include "lrs_regs.svh"
package lrs_pkg;
  typedef enum logic [1:0]
  {
    LRS_RAM    = 2'h0,
    LRS_RAM2   = 2'h1,
    LRS_SHIFT  = 2'h2,
    LRS_SHIFT2 = 2'h3
  } lrs_mode_t;
endpackage : lrs_pkg

// File: design/lrs_fifo.sv
// Purpose: Write-side FIFO with valid/ready on both sides
// Assumes: Single clock, async active-high reset on pointers and fill count only
// Notes:   Data storage has no reset
`timescale 1ns/10ps
`default_nettype none
module lrs_fifo #(
  parameter int WIDTH = 2,
  parameter int DEPTH = 16,
  parameter int PTR_W = 4
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst,
  // Fill side
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  // Drain side
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wrPtr_q;
  logic [PTR_W-1:0] rdPtr_q;
  logic [PTR_W:0]   count_q;
  logic             push;
  logic             pop;

  // Handshake terms
  assign inReady  = (count_q != (PTR_W+1)'(DEPTH));
  assign outValid = (count_q != '0);
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;
  assign outData  = mem[rdPtr_q];

  // Storage write
  always_ff @(posedge sys_clk)
  begin
    if (push)
    begin
      mem[wrPtr_q] <= inData;
    end
  end

  // Pointers and fill count
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end
    else
    begin
      if (push)
      begin
        wrPtr_q <= wrPtr_q + 1'b1;
      end
      if (pop)
      begin
        rdPtr_q <= rdPtr_q + 1'b1;
      end
      if (push && !pop)
      begin
        count_q <= count_q + 1'b1;
      end
      else if (pop && !push)
      begin
        count_q <= count_q - 1'b1;
      end
    end
  end
endmodule : lrs_fifo
`default_nettype wire

// File: design/lrs_lut_store.sv
// Purpose: LUT storage as distributed RAM or addressable shift register
// Assumes: Write requests arrive through a 16-word FIFO; reads are combinational
// Notes:   Cell contents have no reset; only FIFO and address queue pointers and the fill count reset
//          A taken request lands in the cells one clock later
//          Mode is a static strap; changing it mid-stream mixes layouts
//          Reads never wait for the clock; taps follow the address
//          The buffer drains every clock, so writeReady stays high
`timescale 1ns/10ps
`default_nettype none
`include "lrs_regs.svh"
module lrs_lut_store
  import lrs_pkg::*;
(
  // Clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   rst,
  // Mode select, held static during operation
  input  wire lrs_mode_t              mode,
  // Write request: enable, address and data
  input  wire logic                   writeEnable,
  output logic                        writeReady,
  input  wire logic [`LRS_ADDR_W-1:0] writeAddr,
  input  wire logic                   firstWriteData,
  input  wire logic                   secondWriteData,
  // Asynchronous read
  input  wire logic [`LRS_ADDR_W-1:0] readAddr,
  output logic                        lutOut,
  output logic                        lutOut2,
  // Cascade
  output logic                        cascadeTailOut,
  output logic                        sliceMuxOutputD
);
  // Cell array and its next value
  logic [`LRS_DEPTH-1:0]         cells;
  logic [`LRS_DEPTH-1:0]         cellsNext;
  logic [`LRS_DEPTH-1:0]         ramNext;
  logic [`LRS_DEPTH-1:0]         pairNext;
  logic [`LRS_DEPTH-1:0]         shiftNext;
  logic [`LRS_DEPTH-1:0]         dualNext;
  // Request at the head of the buffer
  logic                          fifoValid;
  logic [`LRS_FIFO_W-1:0]        fifoData;
  logic [`LRS_ADDR_W-1:0]        fifoAddr;
  // Address queue beside the data FIFO
  logic [`LRS_ADDR_W-1:0]        addrQueue [`LRS_FIFO_DEPTH];
  logic [`LRS_FIFO_PTR_W-1:0]    aWr_q;
  logic [`LRS_FIFO_PTR_W-1:0]    aRd_q;
  logic                          push;
  // Half-depth indices for the two-bit layouts
  logic [`LRS_HALF_ADDR_W-1:0]   halfAddr;
  logic [`LRS_HALF_ADDR_W-1:0]   wrHalf;
  logic [`LRS_ADDR_W-1:0]        wrLow;
  logic [`LRS_ADDR_W-1:0]        wrHigh;
  logic [`LRS_ADDR_W-1:0]        rdLow;
  logic [`LRS_ADDR_W-1:0]        rdHigh;

  // ----------------------------------------------------------------
  // Write request buffering
  // ----------------------------------------------------------------
  // Data FIFO; the cell array drains one request per clock
  lrs_fifo #(
    .WIDTH (`LRS_FIFO_W),
    .DEPTH (`LRS_FIFO_DEPTH),
    .PTR_W (`LRS_FIFO_PTR_W)
  ) u_fifo (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .inValid  (writeEnable),
    .inReady  (writeReady),
    .inData   ({secondWriteData, firstWriteData}),
    .outValid (fifoValid),
    .outReady (1'b1),
    .outData  (fifoData)
  );

  // Taken request and the address at the buffer head
  assign push     = writeEnable && writeReady;
  assign fifoAddr = addrQueue[aRd_q];

  // Address side queue kept in lock step with the data FIFO
  always_ff @(posedge sys_clk)
  begin
    if (push)
    begin
      addrQueue[aWr_q] <= writeAddr;
    end
  end

  // Address queue pointers
  // Read side steps with every drain, as the FIFO pops each valid cycle
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      aWr_q <= '0;
      aRd_q <= '0;
    end
    else
    begin
      if (push)
      begin
        aWr_q <= aWr_q + 1'b1;
      end
      if (fifoValid)
      begin
        aRd_q <= aRd_q + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Cell update
  // ----------------------------------------------------------------
  // Low four address bits pick the pair in the pair RAM layout
  assign wrHalf = fifoAddr[`LRS_HALF_ADDR_W-1:0];
  assign wrLow  = {1'b0, wrHalf};
  assign wrHigh = {1'b1, wrHalf};

  always_comb
  begin
    ramNext           = cells;
    ramNext[fifoAddr] = fifoData[0];
  end

  always_comb
  begin
    pairNext         = cells;
    pairNext[wrLow]  = fifoData[0];
    pairNext[wrHigh] = fifoData[1];
  end

  assign shiftNext = {cells[`LRS_DEPTH-2:0], fifoData[0]};

  assign dualNext = {cells[`LRS_DEPTH-2:`LRS_HALF_DEPTH], fifoData[1],
                     cells[`LRS_HALF_DEPTH-2:0], fifoData[0]};

  // Next cell contents for the selected mode
  // Only one layout is live; the others are computed and dropped
  always_comb
  begin
    case (mode)
      LRS_RAM:
      begin
        cellsNext = ramNext;
      end
      LRS_RAM2:
      begin
        cellsNext = pairNext;
      end
      LRS_SHIFT:
      begin
        cellsNext = shiftNext;
      end
      LRS_SHIFT2:
      begin
        cellsNext = dualNext;
      end
      default:
      begin
        cellsNext = cells;
      end
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (fifoValid)
    begin
      cells <= cellsNext;
    end
  end

  // ----------------------------------------------------------------
  // Asynchronous read
  // ----------------------------------------------------------------
  // Low four tap bits pick the pair in the two-bit layouts
  assign halfAddr = readAddr[`LRS_HALF_ADDR_W-1:0];
  assign rdLow    = {1'b0, halfAddr};
  assign rdHigh   = {1'b1, halfAddr};

  // follows cells right after the edge
  always_comb
  begin
    case (mode)
      LRS_RAM2,
      LRS_SHIFT2:
      begin
        lutOut  = cells[rdLow];
        lutOut2 = cells[rdHigh];
      end
      default:
      begin
        lutOut  = cells[readAddr];
        lutOut2 = 1'b0;
      end
    endcase
  end

  // last stage on cascade
  // In the dual chain layout this is the tail of the upper chain, fed by secondWriteData
  assign cascadeTailOut  = cells[`LRS_DEPTH-1];
  assign sliceMuxOutputD = cells[`LRS_DEPTH-1];
endmodule : lrs_lut_store
`default_nettype wire

// File: dv/lrs_lut_store_sva.sv
// Purpose: Port checks for the LUT store
// Assumes: One clock, async rst
// Notes:   Bind follows the module
`timescale 1ns/10ps
`default_nettype none
module lrs_lut_store_sva
  import lrs_pkg::*;
(
  // Watched ports
  input wire logic       sys_clk,
  input wire logic       rst,
  input wire lrs_mode_t  mode,
  input wire logic       writeEnable,
  input wire logic       writeReady,
  input wire logic [4:0] writeAddr,
  input wire logic       firstWriteData,
  input wire logic       secondWriteData,
  input wire logic [4:0] readAddr,
  input wire logic       lutOut,
  input wire logic       lutOut2,
  input wire logic       cascadeTailOut,
  input wire logic       sliceMuxOutputD
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Taken request, then one idle clock, with tap and mode held for two clocks
  sequence reqHit(m, a);
    mode == m && writeEnable && writeReady && readAddr == a
    ##1 !writeEnable && $stable(readAddr) && $stable(mode)
    ##1 $stable(readAddr) && $stable(mode);
  endsequence
  ram_write_a:
    assert property (reqHit(LRS_RAM, writeAddr) |-> lutOut == $past(firstWriteData, 2))
    else $error("ram write lost");
  pair_write_a:
    assert property (reqHit(LRS_RAM2, {readAddr[4], writeAddr[3:0]})
      |-> lutOut2 == $past(secondWriteData, 2))
    else $error("pair write lost");
  shift_in_a:
    assert property (reqHit(LRS_SHIFT, 5'h00) |-> lutOut == $past(firstWriteData, 2))
    else $error("shift lost");
  dual_shift_a:
    assert property (reqHit(LRS_SHIFT2, 5'h00) |-> lutOut2 == $past(secondWriteData, 2))
    else $error("dual shift lost");
  tail_mirror_a:
    assert property (cascadeTailOut === sliceMuxOutputD)
    else $error("tail mismatch");
  tail_tap_a:
    assert property ((mode == LRS_RAM || mode == LRS_SHIFT) && readAddr == 5'h1F
      |-> cascadeTailOut == lutOut)
    else $error("tail not last");
  upper_quiet_a:
    assert property (mode == LRS_RAM || mode == LRS_SHIFT |-> !lutOut2)
    else $error("upper output set");
  idle_hold_a:
    assert property (!$past(writeEnable, 2) && $stable(readAddr) && $stable(mode)
      |-> lutOut === $past(lutOut) && cascadeTailOut === $past(cascadeTailOut))
    else $error("change without request");
  ready_a:
    assert property (writeReady)
    else $error("not ready");
endmodule : lrs_lut_store_sva
bind lrs_lut_store lrs_lut_store_sva u_sva (.sys_clk, .rst, .mode, .writeEnable,
  .writeReady, .writeAddr, .firstWriteData, .secondWriteData, .readAddr, .lutOut,
  .lutOut2, .cascadeTailOut, .sliceMuxOutputD);
`default_nettype wire

// File: dv/lrs_user_model.sv
// Purpose: User logic issuing writes and shifts
// Assumes: Called just after a rising edge
// Notes:   Idle lines show inverted last values
`timescale 1ns/10ps
`default_nettype none
module lrs_user_model (
  // Request lines and handshake
  input  wire logic      sys_clk,
  input  wire logic      writeReady,
  output var logic       writeEnable = 1'b0,
  output var logic [4:0] writeAddr = 5'h00,
  output var logic       firstWriteData = 1'b0,
  output var logic       secondWriteData = 1'b0
);
  task automatic req(input logic [4:0] a, input logic d1, input logic d2);
    writeEnable <= 1'b1;
    writeAddr <= a;
    firstWriteData <= d1;
    secondWriteData <= d2;
    @(posedge sys_clk);
    while (writeReady !== 1'b1) @(posedge sys_clk);
  endtask : req
  // Release lines, let the last request land
  task automatic idle();
    writeEnable <= 1'b0;
    writeAddr <= ~writeAddr;
    firstWriteData <= ~firstWriteData;
    secondWriteData <= ~secondWriteData;
    repeat (3) @(posedge sys_clk);
  endtask : idle
endmodule : lrs_user_model
`default_nettype wire

// File: dv/lrs_lut_store_bench.sv
// Purpose: Self-checking bench for the LUT store
// Assumes: User model drives requests
// Notes:   Modes run RAM, pair RAM, shift, dual shift
`timescale 1ns/10ps
`default_nettype none
module lrs_lut_store_bench
  import lrs_pkg::*;
;
  logic       sys_clk = 1'b0;
  logic       rst = 1'b1;
  lrs_mode_t  mode = LRS_RAM;
  logic [4:0] readAddr = 5'h00;
  wire        writeEnable, writeReady, firstWriteData, secondWriteData;
  wire  [4:0] writeAddr;
  wire        lutOut, lutOut2, cascadeTailOut, sliceMuxOutputD;
  int         n_fail = 0, n_tests = 0, cycles = 0;
  lrs_lut_store u_dut (.sys_clk, .rst, .mode, .writeEnable, .writeReady, .writeAddr,
    .firstWriteData, .secondWriteData, .readAddr, .lutOut, .lutOut2, .cascadeTailOut,
    .sliceMuxOutputD);
  lrs_user_model u_user (.sys_clk, .writeReady, .writeEnable, .writeAddr,
    .firstWriteData, .secondWriteData);
  always #4 sys_clk = ~sys_clk;
  // Hang guard
  always @(posedge sys_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      n_fail++;
      final_report();
    end
  end
  task automatic check(input logic seen, input logic exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic final_report();
    $display("tests=%0d fails=%0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : final_report
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Move the tap on an edge, then look once it has settled
  task automatic look(input int a);
    @(posedge sys_clk);
    readAddr <= 5'(a);
    #1;
  endtask : look
  // Fill every cell, overwrite the tapped one, read all back
  task automatic t_ram();
    readAddr <= 5'h05;
    for (int a = 0; a < 32; a++) u_user.req(5'(a), a[0] ^ a[2], 1'b1);
    u_user.req(5'h05, 1'b1, 1'b1);
    u_user.idle();
    for (int a = 0; a < 32; a++)
    begin
      look(a);
      check(lutOut, (a == 5) ? 1'b1 : a[0] ^ a[2]);
    end
    $display("t_ram done");
  endtask : t_ram
  // Pair writes; address bit 4 is ignored
  task automatic t_ram2();
    @(posedge sys_clk);
    mode <= LRS_RAM2;
    readAddr <= 5'h0F;
    for (int a = 0; a < 16; a++) u_user.req(5'(a + 16), a[0], a[1]);
    u_user.idle();
    for (int a = 0; a < 16; a++)
    begin
      look(a);
      check(lutOut, a[0]);
      check(lutOut2, a[1]);
    end
    $display("t_ram2 done");
  endtask : t_ram2
  // Full chain: tail holds old bit until the 32nd shift
  task automatic t_shift();
    @(posedge sys_clk);
    mode <= LRS_SHIFT;
    readAddr <= 5'h00;
    for (int i = 0; i < 31; i++) u_user.req(5'h00, i[2:0] == 3'h0, 1'b0);
    u_user.idle();
    check(cascadeTailOut, 1'b0);
    u_user.req(5'h00, 1'b0, 1'b0);
    u_user.idle();
    check(sliceMuxOutputD, 1'b1);
    check(cascadeTailOut, 1'b1);
    for (int n = 0; n < 32; n++)
    begin
      look(n);
      check(lutOut, n[2:0] == 3'h7);
    end
    $display("t_shift done");
  endtask : t_shift
  // Two half chains on one enable
  task automatic t_shift2();
    @(posedge sys_clk);
    mode <= LRS_SHIFT2;
    readAddr <= 5'h00;
    for (int i = 0; i < 16; i++) u_user.req(5'h00, i[0], i[2]);
    u_user.idle();
    for (int n = 0; n < 16; n++)
    begin
      look(n);
      check(lutOut, ~n[0]);
      check(lutOut2, ~n[2]);
    end
    $display("t_shift2 done");
  endtask : t_shift2
  // Mid-run reset pulse: contents survive, requests still work
  task automatic t_keep();
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    for (int n = 0; n < 16; n++)
    begin
      look(n);
      check(lutOut, ~n[0]);
      check(lutOut2, ~n[2]);
    end
    @(posedge sys_clk);
    readAddr <= 5'h00;
    u_user.req(5'h00, 1'b0, 1'b0);
    u_user.idle();
    check(lutOut, 1'b0);
    check(lutOut2, 1'b0);
    $display("t_keep done");
  endtask : t_keep
  // Reset, then every scenario in turn
  initial
  begin
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    t_ram();
    t_ram2();
    t_shift();
    t_shift2();
    t_keep();
    final_report();
  end
endmodule : lrs_lut_store_bench
`default_nettype wire
